// ===== tksp_defs.svh
`ifndef TKSP_DEFS_SVH
`define TKSP_DEFS_SVH

`define TKSP_CLK_HZ 32'h07735940
`define TKSP_INTEG_LIMIT 3'h4
`define TKSP_THRESHOLD 16'h000a
`define TKSP_HYSTERESIS 16'h0005
`define TKSP_MAXDUR_S 32'h0000001e
`define TKSP_DRIFT_UP_BURSTS 8'h40
`define TKSP_DRIFT_DN_BURSTS 8'h08
`define TKSP_DRIFT_STEP 16'h0001
`define TKSP_CYC_NOM 8'h28
`define TKSP_SPREAD_PERMIL 16'h004b
`define TKSP_PERMIL 16'h03e8
`define TKSP_LFSR_INIT 8'h5a
`define TKSP_DISCH_CYC 8'h40
`define TKSP_BURST_MAX 16'hffff

`endif

// ===== tksp_pkg.sv
package tksp_pkg;
    typedef enum logic [1:0] {
        ST_CAL_START,
        ST_CAL_WAIT,
        ST_MEAS_START,
        ST_MEAS_WAIT
    } tksp_core_state_t;

    typedef enum logic [1:0] {
        BS_IDLE,
        BS_DISCH,
        BS_CHARGE,
        BS_XFER
    } tksp_burst_state_t;

    typedef logic [15:0] tksp_count_t;
endpackage

// ===== tksp_burst_if.sv
`timescale 1ns/100ps
interface tksp_burst_if;
    logic start;
    logic done;
    tksp_pkg::tksp_count_t result;

    modport core (output start, input done, input result);
    modport burst (input start, output done, output result);
endinterface

// ===== tksp_burst.sv
`timescale 1ns/100ps
`include "tksp_defs.svh"
module tksp_burst (
    input wire logic mclk,
    input wire logic rst_n,
    tksp_burst_if.burst bus,
    input wire logic electrodeSenseIn,
    output logic electrodeSenseOut,
    output logic electrodeSenseOe,
    input wire logic sampleCapIn,
    output logic sampleCapOut,
    output logic sampleCapOe
);
    localparam logic [7:0] SPREAD = 8'((`TKSP_CYC_NOM * `TKSP_SPREAD_PERMIL) / `TKSP_PERMIL);

    tksp_pkg::tksp_burst_state_t state_ff, nxt_state;
    logic [7:0] phase_ff, nxt_phase;
    logic [7:0] period_ff, nxt_period;
    logic [7:0] lfsr_ff, nxt_lfsr;
    tksp_pkg::tksp_count_t cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    tksp_pkg::tksp_count_t result_ff, nxt_result;

    // Period drawn within nominal +/- spread, 7 values, nominal drawn twice as often as the others
    function automatic logic [7:0] spreadPeriod(input logic [7:0] rnd);
        logic [7:0] pick;
        pick = (rnd[2:0] == 3'h7) ? SPREAD : {5'h0, rnd[2:0]};
        spreadPeriod = `TKSP_CYC_NOM - SPREAD + pick * SPREAD / 8'h3;
    endfunction

    assign bus.done = done_ff;
    assign bus.result = result_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_period = period_ff;
        nxt_lfsr = {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_result = result_ff;
        electrodeSenseOut = 1'b0;
        electrodeSenseOe = 1'b0;
        sampleCapOut = 1'b0;
        sampleCapOe = 1'b0;
        case (state_ff)
            tksp_pkg::BS_IDLE: begin
                nxt_phase = 8'h0;
            end
            tksp_pkg::BS_DISCH: begin
                // Empty Cs so every burst starts from the same point
                electrodeSenseOe = 1'b1;
                sampleCapOe = 1'b1;
                nxt_phase = phase_ff + 8'h1;
                if (phase_ff == `TKSP_DISCH_CYC) begin
                    nxt_state = tksp_pkg::BS_CHARGE;
                    nxt_phase = 8'h0;
                    nxt_period = spreadPeriod(lfsr_ff);
                end
            end
            tksp_pkg::BS_CHARGE: begin
                electrodeSenseOut = 1'b1;
                electrodeSenseOe = 1'b1;
                sampleCapOe = 1'b1;
                nxt_phase = phase_ff + 8'h1;
                if (phase_ff == (period_ff >> 1)) begin
                    nxt_state = tksp_pkg::BS_XFER;
                end
            end
            default: begin
                nxt_phase = phase_ff + 8'h1;
                if (phase_ff == period_ff) begin
                    nxt_cnt = cnt_ff + 16'h1;
                    nxt_phase = 8'h0;
                    nxt_period = spreadPeriod(lfsr_ff);
                    nxt_state = tksp_pkg::BS_CHARGE;
                    if (sampleCapIn || cnt_ff == `TKSP_BURST_MAX - 16'h1) begin
                        nxt_state = tksp_pkg::BS_IDLE;
                        nxt_done = 1'b1;
                        nxt_result = cnt_ff + 16'h1;
                    end
                end
            end
        endcase
        // Start restarts any burst so recalibration never reuses an old one
        if (bus.start) begin
            nxt_state = tksp_pkg::BS_DISCH;
            nxt_phase = 8'h0;
            nxt_cnt = 16'h0;
            nxt_done = 1'b0;
            nxt_result = result_ff;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= tksp_pkg::BS_IDLE;
            phase_ff <= 8'h0;
            period_ff <= `TKSP_CYC_NOM;
            lfsr_ff <= `TKSP_LFSR_INIT;
            cnt_ff <= 16'h0;
            done_ff <= 1'b0;
            result_ff <= 16'h0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            period_ff <= nxt_period;
            lfsr_ff <= nxt_lfsr;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            result_ff <= nxt_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_period_spread: assert property (@(posedge mclk) disable iff (!rst_n)
        period_ff >= `TKSP_CYC_NOM - SPREAD && period_ff <= `TKSP_CYC_NOM + SPREAD)
        else $error("burst period outside spread band");
    a_burst_cycles: assert property (@(posedge mclk) disable iff (!rst_n)
        done_ff |-> $past(state_ff) == tksp_pkg::BS_XFER && result_ff != 16'h0)
        else $error("burst ended outside a transfer cycle");
endmodule

// ===== tksp_core.sv
`timescale 1ns/100ps
`include "tksp_defs.svh"
// How it works
// - Measure by bursts of charge-transfer cycles
// - Touch only after four consecutive detecting bursts
// - Non-detecting burst clears integrator at once
// - Detection means signal ten above reference, five once touched
// - Recalibrate when detection outlasts about thirty seconds
// - Timeout recalibration leaves toggle state alone
// - Recalibrate at power-up, timeout, override release
// - Reference tracks slowly, frozen during detection
// - Threshold and hysteresis follow the reference
// - Reference falls faster than it rises
// - Burst oscillator spread plus minus 7.5 percent
module tksp_core #(
    parameter logic [31:0] MAX_DUR_CYC = 32'(64'(`TKSP_MAXDUR_S) * 64'(`TKSP_CLK_HZ))
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic electrodeSenseIn,
    output logic electrodeSenseOut,
    output logic electrodeSenseOe,
    input wire logic sampleCapIn,
    output logic sampleCapOut,
    output logic sampleCapOe,
    input wire logic overrideRelease,
    output logic touchDetect,
    output logic recalPulse,
    output tksp_pkg::tksp_count_t referenceLevel,
    output tksp_pkg::tksp_count_t signalLevel
);
    tksp_burst_if burstBus ();

    tksp_burst u_burst (
        .mclk(mclk),
        .rst_n(rst_n),
        .bus(burstBus.burst),
        .electrodeSenseIn(electrodeSenseIn),
        .electrodeSenseOut(electrodeSenseOut),
        .electrodeSenseOe(electrodeSenseOe),
        .sampleCapIn(sampleCapIn),
        .sampleCapOut(sampleCapOut),
        .sampleCapOe(sampleCapOe)
    );

    ////////////////////////////////////////////////////////////////////////////
    tksp_pkg::tksp_core_state_t state_ff, nxt_state;
    tksp_pkg::tksp_count_t ref_ff, nxt_ref;
    tksp_pkg::tksp_count_t sig_ff, nxt_sig;
    logic [2:0] integCnt_ff, nxt_integCnt;
    logic touch_ff, nxt_touch;
    logic [31:0] durCnt_ff, nxt_durCnt;
    logic [7:0] driftCnt_ff, nxt_driftCnt;
    logic recal_ff, nxt_recal;
    logic aboveThr, aboveHyst, detecting, timeout;

    // True when level sits at least margin above the reference
    function automatic logic exceeds(input logic [15:0] lvl, input logic [15:0] refl, input logic [15:0] margin);
        exceeds = {1'b0, lvl} >= {1'b0, refl} + {1'b0, margin};
    endfunction

    assign burstBus.start = (state_ff == tksp_pkg::ST_CAL_START) || (state_ff == tksp_pkg::ST_MEAS_START);
    assign aboveThr = exceeds(burstBus.result, ref_ff, `TKSP_THRESHOLD);
    assign aboveHyst = exceeds(burstBus.result, ref_ff, `TKSP_HYSTERESIS);
    assign detecting = touch_ff ? aboveHyst : aboveThr;
    assign timeout = touch_ff && durCnt_ff >= MAX_DUR_CYC - 32'h1;
    assign touchDetect = touch_ff;
    assign recalPulse = recal_ff;
    assign referenceLevel = ref_ff;
    assign signalLevel = sig_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_ref = ref_ff;
        nxt_sig = sig_ff;
        nxt_integCnt = integCnt_ff;
        nxt_touch = touch_ff;
        nxt_durCnt = touch_ff ? durCnt_ff + 32'h1 : 32'h0;
        nxt_driftCnt = driftCnt_ff;
        nxt_recal = 1'b0;
        case (state_ff)
            tksp_pkg::ST_CAL_START: begin
                nxt_state = tksp_pkg::ST_CAL_WAIT;
            end
            tksp_pkg::ST_CAL_WAIT: begin
                if (burstBus.done) begin
                    nxt_ref = burstBus.result;
                    nxt_sig = burstBus.result;
                    nxt_integCnt = 3'h0;
                    nxt_touch = 1'b0;
                    nxt_durCnt = 32'h0;
                    nxt_driftCnt = 8'h0;
                    nxt_state = tksp_pkg::ST_MEAS_START;
                end
            end
            tksp_pkg::ST_MEAS_START: begin
                nxt_state = tksp_pkg::ST_MEAS_WAIT;
            end
            default: begin
                if (burstBus.done) begin
                    nxt_sig = burstBus.result;
                    nxt_state = tksp_pkg::ST_MEAS_START;
                    if (detecting) begin
                        nxt_driftCnt = 8'h0;
                        if (!touch_ff) begin
                            nxt_integCnt = integCnt_ff + 3'h1;
                            if (integCnt_ff == `TKSP_INTEG_LIMIT - 3'h1) begin
                                nxt_touch = 1'b1;
                                nxt_integCnt = 3'h0;
                            end
                        end
                    end else begin
                        nxt_integCnt = 3'h0;
                        nxt_touch = 1'b0;
                        // Tracking only while nothing is pending; a slow rise
                        // must not swallow an approaching finger
                        if (!touch_ff && integCnt_ff == 3'h0) begin
                            nxt_driftCnt = driftCnt_ff + 8'h1;
                            if (burstBus.result == ref_ff) begin
                                nxt_driftCnt = 8'h0;
                            end else if (burstBus.result < ref_ff) begin
                                if (driftCnt_ff >= `TKSP_DRIFT_DN_BURSTS - 8'h1) begin
                                    nxt_ref = ref_ff - `TKSP_DRIFT_STEP;
                                    nxt_driftCnt = 8'h0;
                                end
                            end else if (driftCnt_ff >= `TKSP_DRIFT_UP_BURSTS - 8'h1) begin
                                nxt_ref = ref_ff + `TKSP_DRIFT_STEP;
                                nxt_driftCnt = 8'h0;
                            end
                        end
                    end
                end
            end
        endcase
        // Obstruction or override release; no toggle state is kept here
        if (timeout || overrideRelease) begin
            nxt_state = tksp_pkg::ST_CAL_START;
            nxt_recal = 1'b1;
            nxt_integCnt = 3'h0;
            nxt_touch = 1'b0;
            nxt_durCnt = 32'h0;
        end
    end

    // Reset lands in calibration, which is the power-up recalibration
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= tksp_pkg::ST_CAL_START;
            ref_ff <= 16'h0;
            sig_ff <= 16'h0;
            integCnt_ff <= 3'h0;
            touch_ff <= 1'b0;
            durCnt_ff <= 32'h0;
            driftCnt_ff <= 8'h0;
            recal_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ref_ff <= nxt_ref;
            sig_ff <= nxt_sig;
            integCnt_ff <= nxt_integCnt;
            touch_ff <= nxt_touch;
            durCnt_ff <= nxt_durCnt;
            driftCnt_ff <= nxt_driftCnt;
            recal_ff <= nxt_recal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic measDone;
    assign measDone = burstBus.done && state_ff == tksp_pkg::ST_MEAS_WAIT && !timeout && !overrideRelease;

    // Drift is only legal from an idle integrator with no touch
    logic driftOpen;
    assign driftOpen = measDone && !touch_ff && integCnt_ff == 3'h0;

    a_touch_needs_four: assert property ($rose(touch_ff) |-> $past(integCnt_ff) == `TKSP_INTEG_LIMIT - 3'h1
        && $past(measDone))
        else $error("touch set without four detecting bursts");
    a_integ_clear_miss: assert property (measDone && !detecting |=> integCnt_ff == 3'h0)
        else $error("integrator not cleared on missed burst");
    a_det_threshold: assert property (measDone && !touch_ff && burstBus.result >= ref_ff + `TKSP_THRESHOLD
        && ref_ff <= 16'hffff - `TKSP_THRESHOLD |=> integCnt_ff != 3'h0 || touch_ff)
        else $error("burst above threshold not counted");
    a_dur_idle_zero: assert property (!touch_ff |=> durCnt_ff == 32'h0)
        else $error("duration timer ran without a touch");
    a_dur_counts: assert property (touch_ff && !timeout && !overrideRelease
        && state_ff != tksp_pkg::ST_CAL_WAIT |=> durCnt_ff == $past(durCnt_ff) + 32'h1)
        else $error("duration timer missed a cycle");
    a_recal_clears: assert property (timeout || overrideRelease |=> !touch_ff && integCnt_ff == 3'h0
        && durCnt_ff == 32'h0 && state_ff == tksp_pkg::ST_CAL_START)
        else $error("recalibration left sensing state behind");
    a_timeout_recal: assert property (touch_ff && durCnt_ff == MAX_DUR_CYC - 32'h1 |=> recal_ff
        && state_ff == tksp_pkg::ST_CAL_START)
        else $error("max duration did not recalibrate");
    a_override_recal: assert property (overrideRelease |=> recal_ff ##1 state_ff == tksp_pkg::ST_CAL_WAIT)
        else $error("override release did not recalibrate");
    a_ref_frozen: assert property (touch_ff || integCnt_ff != 3'h0 |=> $stable(ref_ff)
        || $past(state_ff) == tksp_pkg::ST_CAL_WAIT)
        else $error("reference moved during detection");
    a_ref_slew: assert property (state_ff != tksp_pkg::ST_CAL_WAIT |=> ref_ff == $past(ref_ff)
        || ref_ff == $past(ref_ff) + `TKSP_DRIFT_STEP || ref_ff == $past(ref_ff) - `TKSP_DRIFT_STEP)
        else $error("reference stepped too far");
    a_drift_up_slow: assert property (driftOpen && burstBus.result > ref_ff
        && driftCnt_ff < `TKSP_DRIFT_UP_BURSTS - 8'h1 |=> $stable(ref_ff))
        else $error("reference rose before the slow rate allowed");
    a_drift_down_step: assert property (driftOpen && burstBus.result < ref_ff
        && driftCnt_ff >= `TKSP_DRIFT_DN_BURSTS - 8'h1 |=> ref_ff == $past(ref_ff) - `TKSP_DRIFT_STEP)
        else $error("reference did not follow a falling signal");
    a_recal_load: assert property (state_ff == tksp_pkg::ST_CAL_WAIT && burstBus.done && !timeout
        && !overrideRelease |=> ref_ff == $past(burstBus.result) && durCnt_ff == 32'h0 && integCnt_ff == 3'h0)
        else $error("recalibration did not reload reference");
    a_drop_touch: assert property (measDone && touch_ff && !aboveHyst |=> !touch_ff)
        else $error("touch held below hysteresis");
    a_touch_holds: assert property (measDone && touch_ff && aboveHyst |=> touch_ff)
        else $error("touch dropped while above hysteresis");

    c_touch: cover property ($rose(touch_ff));
    c_timeout: cover property (timeout ##1 recal_ff);
    c_drift_down: cover property (measDone && !touch_ff ##1 ref_ff == $past(ref_ff) - 16'h1);
    c_bounce: cover property (integCnt_ff == 3'h3 ##1 integCnt_ff == 3'h0 && !touch_ff);
endmodule

// ===== tksp_electrode_model.sv
`timescale 1ns/100ps
module tksp_electrode_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic electrodeSenseOut,
    input wire logic electrodeSenseOe,
    input wire logic sampleCapOut,
    input wire logic sampleCapOe,
    input wire logic [15:0] target,
    output logic sampleCapIn,
    output logic electrodeSenseIn,
    output logic [15:0] burstCount
);
    logic [15:0] chargeCnt;
    logic [15:0] goal;
    logic wasCharge;
    logic wasDisch;
    logic charge;
    logic disch;
    logic tripped;
    assign charge = electrodeSenseOe && electrodeSenseOut;
    assign disch = electrodeSenseOe && !electrodeSenseOut;
    // Cap reaches trip level once enough charge packets arrived
    assign tripped = (chargeCnt != 16'h0000) && (chargeCnt >= goal);
    // Released pins show the cap level, never the last driven value
    assign sampleCapIn = sampleCapOe ? sampleCapOut : tripped;
    assign electrodeSenseIn = electrodeSenseOe ? electrodeSenseOut : tripped;
    ////////////////////////////////////////
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chargeCnt <= 16'h0000;
            goal <= 16'hffff;
            wasCharge <= 1'b0;
            wasDisch <= 1'b0;
            burstCount <= 16'h0000;
        end else begin
            wasCharge <= charge;
            wasDisch <= disch;
            if (disch && !wasDisch) begin
                burstCount <= burstCount + 16'h0001;
                chargeCnt <= 16'h0000;
            end else if (charge && !wasCharge) begin
                // Goal latched late so the bench may change it after discharge starts
                if (chargeCnt == 16'h0000) begin
                    goal <= target;
                end
                chargeCnt <= chargeCnt + 16'h0001;
            end
        end
    end
endmodule

// ===== test_touch_key_signal_processing.sv
`timescale 1ns/100ps
module test_touch_key_signal_processing;
    // Short timeout, still longer than the integrator scenario holds a touch
    localparam logic [31:0] MAX_DUR = 32'h00002ee0;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic overrideRelease = 1'b0;
    logic [15:0] target = 16'h0014;
    logic eIn, eOut, eOe, cIn, cOut, cOe, touchDetect, recalPulse;
    logic [15:0] burstCount;
    tksp_pkg::tksp_count_t referenceLevel, signalLevel;
    logic prevCharge = 1'b0;
    int errTotal = 0;
    int testsRun = 0;
    int cyc = 0;
    int lastCharge = 0;
    int minPer = 1000;
    int maxPer = 0;
    always #4 mclk = ~mclk;
    tksp_core #(.MAX_DUR_CYC(MAX_DUR)) uut (.mclk(mclk), .rst_n(rst_n), .electrodeSenseIn(eIn),
        .electrodeSenseOut(eOut), .electrodeSenseOe(eOe), .sampleCapIn(cIn), .sampleCapOut(cOut),
        .sampleCapOe(cOe), .overrideRelease(overrideRelease), .touchDetect(touchDetect),
        .recalPulse(recalPulse), .referenceLevel(referenceLevel), .signalLevel(signalLevel));
    tksp_electrode_model far (.mclk(mclk), .rst_n(rst_n), .electrodeSenseOut(eOut), .electrodeSenseOe(eOe),
        .sampleCapOut(cOut), .sampleCapOe(cOe), .target(target), .sampleCapIn(cIn),
        .electrodeSenseIn(eIn), .burstCount(burstCount));
    // Spacing of charge pulses inside a burst
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        prevCharge <= eOe & eOut;
        if (eOe && !eOut) begin
            lastCharge <= 0;
        end else if (eOe && eOut && !prevCharge) begin
            if (lastCharge != 0 && cyc - lastCharge < minPer) minPer <= cyc - lastCharge;
            if (lastCharge != 0 && cyc - lastCharge > maxPer) maxPer <= cyc - lastCharge;
            lastCharge <= cyc;
        end
    end
    ////////////////////////////////////////
    task automatic conclude;
        if (errTotal == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic waitBursts(input int n);
        logic [15:0] first;
        int k;
        first = burstCount;
        for (k = 0; k < 20000 * n && burstCount !== first + 16'(n); k++) @(posedge mclk);
        check("burst progress", first + 16'(n), burstCount);
        if (burstCount !== first + 16'(n)) conclude();
        #1;
    endtask
    task automatic burst(input logic [15:0] t, input int n);
        @(posedge mclk);
        target <= t;
        waitBursts(n);
    endtask
    ////////////////////////////////////////
    task automatic scnCalib;
        waitBursts(2);
        check("calibrated reference", 16'h0014, referenceLevel);
        check("burst result", 16'h0014, signalLevel);
    endtask
    task automatic scnIntegrator;
        burst(16'h001d, 5);
        check("touch nine over", 16'h0000, touchDetect);
        burst(16'h001e, 3);
        burst(16'h0014, 1);
        burst(16'h001e, 3);
        check("touch split run", 16'h0000, touchDetect);
        burst(16'h001e, 1);
        check("touch after four", 16'h0001, touchDetect);
        burst(16'h001e, 2);
        check("frozen reference", 16'h0014, referenceLevel);
        burst(16'h0019, 1);
        check("touch at hysteresis", 16'h0001, touchDetect);
        burst(16'h0018, 1);
        check("touch released", 16'h0000, touchDetect);
    endtask
    task automatic scnTimeout;
        int k;
        burst(16'h001e, 4);
        check("touch held", 16'h0001, touchDetect);
        for (k = 0; k < 20000 && recalPulse !== 1'b1; k++) @(posedge mclk);
        check("timeout length", 16'h0001, 16'(k + 16 >= int'(MAX_DUR) && k <= int'(MAX_DUR) + 16));
        @(posedge mclk);
        #1;
        check("touch after timeout", 16'h0000, touchDetect);
        waitBursts(3);
        check("reference after timeout", 16'h001e, referenceLevel);
        check("no touch after recal", 16'h0000, touchDetect);
    endtask
    task automatic scnOverride;
        int k;
        burst(16'h000e, 1);
        @(posedge mclk);
        overrideRelease <= 1'b1;
        @(posedge mclk);
        overrideRelease <= 1'b0;
        for (k = 0; k < 3 && recalPulse !== 1'b1; k++) @(posedge mclk);
        check("override recal", 16'h0001, recalPulse);
        waitBursts(3);
        check("reference after override", 16'h000e, referenceLevel);
    endtask
    task automatic scnDrift;
        burst(16'h000c, 4);
        check("slow drift", 16'h000e, referenceLevel);
        burst(16'h000c, 6);
        check("drift down", 16'h000d, referenceLevel);
        burst(16'h0010, 16);
        check("slow drift up", 16'h000d, referenceLevel);
    endtask
    task automatic scnSpread;
        check("period spread", 16'h0001, 16'(maxPer - minPer >= 2 && maxPer - minPer <= 7));
        check("period centre", 16'h0001, 16'(minPer + maxPer >= 76 && minPer + maxPer <= 86));
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        scnCalib();
        scnIntegrator();
        scnTimeout();
        scnOverride();
        scnDrift();
        scnSpread();
        conclude();
    end
endmodule
